//--- hdl/usbt_consts.vh
// Constants for the USB transmit endpoint FIFO status block
`ifndef USBT_CONSTS_VH
`define USBT_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define USBT_ADDR_STAT      8'hf2
`define USBT_ADDR_DATA      8'hf3
`define USBT_ADDR_FLAG      8'hf5
`define USBT_ADDR_COUNT     8'hf6

// ****************************************************************
// Reset values
// ****************************************************************
`define USBT_RST_STAT       8'h00
`define USBT_RST_FLAG       8'h08

// ****************************************************************
// Flag register field positions
// ****************************************************************
`define USBT_FLG_PSET_HI    7
`define USBT_FLG_PSET_LO    6
`define USBT_FLG_EMPTY      3
`define USBT_FLG_FULL       2
`define USBT_FLG_URF        1
`define USBT_FLG_OVF        0

// ****************************************************************
// Status register field positions
// ****************************************************************
`define USBT_STA_SEQ        7
`define USBT_STA_FLUSH      4
`define USBT_STA_OVW        3
`define USBT_STA_VOID       2
`define USBT_STA_ERR        1
`define USBT_STA_ACK        0

// ****************************************************************
// Packet set codes and sizes
// ****************************************************************
`define USBT_PSET_NONE      2'h0
`define USBT_PSET_ONE       2'h1
`define USBT_PSET_TWO       2'h3
`define USBT_NUM_EP         4
`define USBT_EP_W           2
`define USBT_PTR_W          5

`endif

//--- hdl/usbt_tx_status.v
// USB transmit endpoint FIFO flag and status logic
//
// Contract
// - Byte-count write steps packet sets 00-01-11; at 11 raises overrun.
// - Empty bit 3 set when pointers equal without wrap.
// - Full bit 2 set when write pointer wrapped equals read marker.
// - Empty and full always track present state, never deferred.
// - Sticky underrun bit 1 on reading past contents; firmware clears.
// - On underrun the read pointer stays at empty position.
// - Count mismatch flags underrun and corrupts the sent packet.
// - Isochronous underrun flag is set only at next start-of-frame.
// - Sticky overrun bit 0 on write to full or count at 11.
// - On overrun the write pointer stays at full position.
// - Isochronous overrun flag updates immediately.
// - Underrun or overrun set makes every non-isochronous transmit request NAK; isochronous ones get no answer.
// - Toggle bit 7 goes in data PID, flips on non-isochronous ACK and on SETUP.
// - Toggle written only with overwrite-enable 1; enable reads back 0.
// - Isochronous sets at 11 unread at frame start: flush oldest, flag bit 4.
// - Void bit 2 on IN while not ready; other status untouched.
// - Void, error, acknowledge update at transaction end; isochronous at frame start.
// - Error bit 1 on missing handshake or underrun while sending.
// - Acknowledge bit 0 on acknowledged completion; never with error.
// - Error or acknowledge activity sets the endpoint transmit-done flag.
// - Registers show the endpoint chosen by the endpoint index.
`timescale 1ns/1ps
`include "usbt_consts.vh"
`default_nettype none

module usbt_tx_status
(
    input  wire                         mclk,
    input  wire                         reset,
    input  wire                         clk_en,
    input  wire [7:0]                   sfr_addr,
    input  wire [7:0]                   sfr_wdata,
    input  wire                         sfr_wr,
    input  wire                         sfr_rd,
    output reg  [7:0]                   sfr_rdata,
    input  wire [`USBT_EP_W-1:0]        ep_sel,
    input  wire                         fifo_clear,
    input  wire [`USBT_NUM_EP-1:0]      ep_iso_mode,
    input  wire [`USBT_NUM_EP-1:0]      ep_tx_enable,
    input  wire [`USBT_NUM_EP-1:0]      tx_done_clear,
    output wire [`USBT_NUM_EP-1:0]      endpoint_tx_done_flag,
    input  wire [`USBT_EP_W-1:0]        usb_ep,
    input  wire                         usb_in_token,
    input  wire                         usb_setup_token,
    input  wire                         usb_rd_byte,
    input  wire                         usb_txn_ack,
    input  wire                         usb_txn_timeout,
    input  wire                         usb_sof,
    output wire                         usb_nak,
    output wire                         usb_send,
    output wire                         usb_data_toggle,
    output wire                         usb_corrupt
);

    // ****************************************************************
    // Shared strobes and per-endpoint views
    // ****************************************************************
    wire [8*`USBT_NUM_EP-1:0]           stat_v;
    wire [8*`USBT_NUM_EP-1:0]           flag_v;
    wire [`USBT_NUM_EP-1:0]             ready_v;
    wire [`USBT_NUM_EP-1:0]             seq_v;
    wire [`USBT_NUM_EP-1:0]             corrupt_v;
    wire                                wr_stat;
    wire                                wr_data;
    wire                                wr_flag;
    wire                                wr_count;

    // Firmware write decode from strobe and address only; the clocked users apply the clock enable
    assign wr_stat  = sfr_wr && (sfr_addr == `USBT_ADDR_STAT);
    assign wr_data  = sfr_wr && (sfr_addr == `USBT_ADDR_DATA);
    assign wr_flag  = sfr_wr && (sfr_addr == `USBT_ADDR_FLAG);
    assign wr_count = sfr_wr && (sfr_addr == `USBT_ADDR_COUNT);

    // Packet set arithmetic on the 00, 01, 11 encoding
    function [1:0] usbt_step;
        input [1:0] code;
        input       inc;
        input       dec;
        reg   [1:0] cnt;
        begin
            cnt = (code == `USBT_PSET_NONE) ? 2'h0 : ((code == `USBT_PSET_TWO) ? 2'h2 : 2'h1);
            cnt = cnt + {1'b0, inc} - {1'b0, dec};
            usbt_step = (cnt == 2'h0) ? `USBT_PSET_NONE :
                        ((cnt == 2'h1) ? `USBT_PSET_ONE : `USBT_PSET_TWO);
        end
    endfunction

    // ****************************************************************
    // Per-endpoint FIFO state
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < `USBT_NUM_EP; i = i + 1)
        begin : g_ep
            reg  [`USBT_PTR_W-1:0] wptr;
            reg  [`USBT_PTR_W-1:0] rptr;
            reg  [`USBT_PTR_W-1:0] rmark;
            reg  [`USBT_PTR_W-1:0] end_old;
            reg  [`USBT_PTR_W-1:0] end_new;
            reg  [1:0]             pset;
            reg                    urf;
            reg                    urf_pend;
            reg                    ovf;
            reg                    seq;
            reg                    flushed;
            reg                    void_b;
            reg                    err_b;
            reg                    ack_b;
            reg                    pv;
            reg                    pe;
            reg                    pa;
            reg                    pend_upd;
            reg                    pend_dec;
            reg                    in_seen;
            reg                    corrupt;
            reg                    done;
            wire                   fw;
            wire                   us;
            wire                   iso;
            wire                   empty;
            wire                   full;
            wire                   clr;
            wire                   inc;
            wire                   dec;
            wire                   flush;
            wire                   u_in;
            wire                   u_end;
            wire                   u_rd;
            wire                   sof_iso;
            wire                   new_err;
            wire                   cnt_zero;

            assign fw      = (ep_sel == i);
            assign us      = (usb_ep == i);
            assign iso     = ep_iso_mode[i];
            assign clr     = fifo_clear && fw;
            assign u_in    = usb_in_token && us;
            assign u_end   = (usb_txn_ack || usb_txn_timeout) && us;
            assign u_rd    = usb_rd_byte && us;
            assign sof_iso = usb_sof && iso;

            // Flags follow the pointers combinationally in every mode
            assign empty = (wptr == rptr);
            assign full  = (wptr[3:0] == rmark[3:0]) && (wptr[4] != rmark[4]);

            // Any sticky FIFO error forces a NAK, or silence when isochronous; empty packet sets are not ready
            assign ready_v[i] = (pset != `USBT_PSET_NONE) && ep_tx_enable[i]
                                && !urf && !ovf;

            // Set changes: firmware adds now, USB removes now or at frame start
            assign flush    = sof_iso && (pset == `USBT_PSET_TWO) && !in_seen;
            assign inc      = wr_count && fw && (pset != `USBT_PSET_TWO);
            assign dec      = (u_end && !iso && usb_txn_ack)
                              || (sof_iso && (pend_dec || flush));
            assign cnt_zero = (pset == `USBT_PSET_NONE) || (dec && pset != `USBT_PSET_TWO);
            assign new_err  = corrupt || (usb_txn_timeout && !iso);

            // Pointers, markers and packet sets
            always @(posedge mclk or posedge reset)
            begin
                if (reset)
                begin
                    wptr    <= {`USBT_PTR_W{1'b0}};
                    rptr    <= {`USBT_PTR_W{1'b0}};
                    rmark   <= {`USBT_PTR_W{1'b0}};
                    end_old <= {`USBT_PTR_W{1'b0}};
                    end_new <= {`USBT_PTR_W{1'b0}};
                    pset    <= `USBT_PSET_NONE;
                end
                else if (clk_en)
                begin
                    if (clr)
                    begin
                        wptr    <= {`USBT_PTR_W{1'b0}};
                        rptr    <= {`USBT_PTR_W{1'b0}};
                        rmark   <= {`USBT_PTR_W{1'b0}};
                        end_old <= {`USBT_PTR_W{1'b0}};
                        end_new <= {`USBT_PTR_W{1'b0}};
                        pset    <= `USBT_PSET_NONE;
                    end
                    else
                    begin
                        if (wr_data && fw && !full)
                            wptr <= wptr + 1'b1;
                        if (flush)
                            rptr <= end_old;
                        else if (u_end && !iso && usb_txn_timeout)
                            rptr <= rmark;
                        else if (u_rd && !empty)
                            rptr <= rptr + 1'b1;
                        if (dec)
                        begin
                            rmark   <= end_old;
                            end_old <= end_new;
                        end
                        if (inc && cnt_zero)
                            end_old <= wptr;
                        else if (inc)
                            end_new <= wptr;
                        pset <= usbt_step(pset, inc, dec);
                    end
                end
            end

            // Sticky errors, toggle and transaction status
            always @(posedge mclk or posedge reset)
            begin
                if (reset)
                begin
                    urf      <= 1'b0;
                    urf_pend <= 1'b0;
                    ovf      <= 1'b0;
                    seq      <= 1'b0;
                    flushed  <= 1'b0;
                    void_b   <= 1'b0;
                    err_b    <= 1'b0;
                    ack_b    <= 1'b0;
                    pv       <= 1'b0;
                    pe       <= 1'b0;
                    pa       <= 1'b0;
                    pend_upd <= 1'b0;
                    pend_dec <= 1'b0;
                    in_seen  <= 1'b0;
                    corrupt  <= 1'b0;
                    done     <= 1'b0;
                end
                else if (clk_en)
                begin
                    // Overrun: firmware events act at once in every mode
                    if ((wr_data && fw && full) || (wr_count && fw && pset == `USBT_PSET_TWO))
                        ovf <= 1'b1;
                    else if (wr_flag && fw && !sfr_wdata[`USBT_FLG_OVF])
                        ovf <= 1'b0;
                    // Underrun: at once, or held until frame start when isochronous
                    if (u_rd && empty && !iso)
                        urf <= 1'b1;
                    else if (sof_iso && urf_pend)
                        urf <= 1'b1;
                    else if (wr_flag && fw && !sfr_wdata[`USBT_FLG_URF])
                        urf <= 1'b0;
                    if (u_rd && empty && iso)
                        urf_pend <= 1'b1;
                    else if (sof_iso)
                        urf_pend <= 1'b0;
                    // Underrun inside a packet spoils its stuffing and CRC
                    if (u_rd && empty)
                        corrupt <= 1'b1;
                    else if (u_in || clr)
                        corrupt <= 1'b0;
                    // Toggle: firmware overwrite needs the enable bit in the same write
                    if (wr_stat && fw && sfr_wdata[`USBT_STA_OVW])
                        seq <= sfr_wdata[`USBT_STA_SEQ];
                    else if ((u_end && !iso && usb_txn_ack) || (usb_setup_token && us))
                        seq <= ~seq;
                    // Flush marker
                    if (flush)
                        flushed <= 1'b1;
                    else if (clr)
                        flushed <= 1'b0;
                    if (u_in)
                        in_seen <= 1'b1;
                    else if (usb_sof)
                        in_seen <= 1'b0;
                    if (u_end && iso)
                        pend_dec <= 1'b1;
                    else if (sof_iso)
                        pend_dec <= 1'b0;
                    // Non-isochronous status updates at transaction end
                    if (u_end && !iso)
                    begin
                        err_b  <= new_err;
                        ack_b  <= !new_err;
                        void_b <= 1'b0;
                    end
                    else if (u_in && !ready_v[i] && !iso)
                        void_b <= 1'b1;
                    else if (sof_iso && pend_upd)
                    begin
                        err_b  <= pe;
                        ack_b  <= pa;
                        void_b <= pv;
                    end
                    // Isochronous results wait for the next frame start
                    if (sof_iso)
                        pend_upd <= 1'b0;
                    else if (u_end && iso)
                    begin
                        pend_upd <= 1'b1;
                        pe       <= corrupt;
                        pa       <= !corrupt;
                        pv       <= 1'b0;
                    end
                    else if (u_in && !ready_v[i] && iso)
                    begin
                        pend_upd <= 1'b1;
                        pv       <= 1'b1;
                        if (!pend_upd)
                        begin
                            pe <= err_b;
                            pa <= ack_b;
                        end
                    end
                    // Transmit done follows any error or acknowledge result
                    if ((u_end && !iso) || (sof_iso && pend_upd && (pe || pa)))
                        done <= 1'b1;
                    else if (tx_done_clear[i])
                        done <= 1'b0;
                end
            end

            // Readback images; reserved bits and the enable bit read zero
            assign stat_v[8*i+7:8*i] = {seq, 2'b00, flushed, 1'b0, void_b, err_b, ack_b};
            assign flag_v[8*i+7:8*i] = {pset, 2'b00, empty, full, urf, ovf};
            assign seq_v[i]     = seq;
            assign corrupt_v[i] = corrupt;
            assign endpoint_tx_done_flag[i] = done;
        end
    endgenerate

    // ****************************************************************
    // Register read port
    // ****************************************************************
    // Selected endpoint image, one cycle after the read strobe
    always @(posedge mclk or posedge reset)
    begin
        if (reset)
            sfr_rdata <= 8'h00;
        else if (clk_en && sfr_rd)
        begin
            case (sfr_addr)
                `USBT_ADDR_STAT: sfr_rdata <= stat_v[8*ep_sel +: 8];
                `USBT_ADDR_FLAG: sfr_rdata <= flag_v[8*ep_sel +: 8];
                default:         sfr_rdata <= 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // USB engine answers
    // ****************************************************************
    // Isochronous endpoints stay silent instead of NAKing
    assign usb_send        = usb_in_token && ready_v[usb_ep];
    assign usb_nak         = usb_in_token && !ready_v[usb_ep] && !ep_iso_mode[usb_ep];
    assign usb_data_toggle = seq_v[usb_ep];
    assign usb_corrupt     = corrupt_v[usb_ep];

endmodule // usbt_tx_status

`default_nettype wire

//--- tb/usbt_host_model.sv
// Host and engine model issuing tokens, byte reads and handshakes
`timescale 1ns/1ps
`default_nettype none
module usbt_host_model
(
    input  wire logic       mclk,
    input  wire logic       usb_nak,
    input  wire logic       usb_send,
    input  wire logic       usb_data_toggle,
    output logic [1:0]      usb_ep = 2'h0,
    output logic            usb_in_token = 1'b0,
    output wire logic       usb_rd_byte,
    output wire logic       usb_txn_ack,
    output wire logic       usb_txn_timeout,
    output wire logic       usb_setup_token,
    output wire logic       usb_sof
);
    // ********
    // Event strobes
    // ********
    logic [4:0] st = 5'h00;
    // One strobe bit per USB event kind
    assign {usb_sof, usb_setup_token, usb_txn_timeout, usb_txn_ack, usb_rd_byte} = st;
    // One-cycle pulse of event k
    task automatic pulse(input int k);
        @(posedge mclk);
        st[k] <= 1'b1;
        @(posedge mclk);
        st[k] <= 1'b0;
    endtask
    // IN transaction; a refused token ends it, else bytes, then handshake or silence
    task automatic xfer(input logic [1:0] ep, input int n, input logic ok, input int gap,
                        output logic [7:0] ans);
        @(posedge mclk);
        usb_ep <= ep;
        usb_in_token <= 1'b1;
        #1 ans = {5'h00, usb_send, usb_nak, usb_data_toggle};
        @(posedge mclk);
        usb_in_token <= 1'b0;
        if (ans[2])
        begin
            repeat (n)
            begin
                pulse(0);
                repeat (gap) @(posedge mclk);
            end
            pulse(ok ? 1 : 2);
        end
    endtask
endmodule // usbt_host_model
`default_nettype wire

//--- tb/usbt_tx_status_assertions.sv
// Assertion checker bound to the transmit status block
`timescale 1ns/1ps
`default_nettype none
module usbt_checker
(
    input wire logic       mclk,
    input wire logic       reset,
    input wire logic       clk_en,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic [3:0] ep_iso_mode,
    input wire logic [3:0] endpoint_tx_done_flag,
    input wire logic [1:0] usb_ep,
    input wire logic       usb_in_token,
    input wire logic       usb_setup_token,
    input wire logic       usb_txn_ack,
    input wire logic       usb_txn_timeout,
    input wire logic       usb_sof,
    input wire logic       usb_nak,
    input wire logic       usb_send,
    input wire logic       usb_data_toggle
);
    // ********
    // Properties on the USB answer and register reads
    // ********
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    property p_send_token; usb_send |-> usb_in_token && !usb_nak; endproperty
    a_send_token: assert property (p_send_token) else $error("send without token");
    property p_nak_token; usb_nak |-> usb_in_token && !ep_iso_mode[usb_ep]; endproperty
    a_nak_token: assert property (p_nak_token) else $error("nak out of place");
    property p_ack_flip;
        clk_en && usb_txn_ack && !ep_iso_mode[usb_ep] && !usb_setup_token && !sfr_wr
        ##1 $stable(usb_ep) |-> usb_data_toggle != $past(usb_data_toggle);
    endproperty
    a_ack_flip: assert property (p_ack_flip) else $error("toggle kept after ack");
    property p_setup_flip;
        clk_en && usb_setup_token && !usb_txn_ack && !sfr_wr
        ##1 $stable(usb_ep) |-> usb_data_toggle != $past(usb_data_toggle);
    endproperty
    a_setup_flip: assert property (p_setup_flip) else $error("toggle kept after setup");
    property p_toggle_hold;
        !usb_txn_ack && !usb_setup_token && !usb_sof && !sfr_wr
        ##1 $stable(usb_ep) |-> $stable(usb_data_toggle);
    endproperty
    a_toggle_hold: assert property (p_toggle_hold) else $error("toggle moved alone");
    property p_done_set;
        clk_en && (usb_txn_ack || usb_txn_timeout) && !ep_iso_mode[usb_ep]
        |=> endpoint_tx_done_flag[$past(usb_ep)];
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag not set");
    property p_void_no_done;
        usb_nak && !usb_txn_ack && !usb_txn_timeout && !usb_sof
        |=> !endpoint_tx_done_flag[$past(usb_ep)] || $past(endpoint_tx_done_flag[usb_ep]);
    endproperty
    a_void_no_done: assert property (p_void_no_done) else $error("void set done");
    property p_unmapped;
        clk_en && sfr_rd && !(sfr_addr inside {8'hf2, 8'hf3, 8'hf5, 8'hf6}) |=> sfr_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_stat_bits;
        clk_en && sfr_rd && sfr_addr == 8'hf2 |=> !sfr_rdata[3] && !(sfr_rdata[1] && sfr_rdata[0]);
    endproperty
    a_stat_bits: assert property (p_stat_bits) else $error("status bits clash");
    property p_flag_excl; clk_en && sfr_rd && sfr_addr == 8'hf5 |=> !(sfr_rdata[3] && sfr_rdata[2]);
    endproperty
    a_flag_excl: assert property (p_flag_excl) else $error("empty and full together");
    c_send: cover property (usb_send);
    c_nak: cover property (usb_nak);
    c_iso_sof: cover property (usb_sof && |ep_iso_mode);
endmodule // usbt_checker
bind usbt_tx_status usbt_checker usbt_checker_i (.mclk, .reset, .clk_en, .sfr_addr, .sfr_wr,
    .sfr_rd, .sfr_rdata, .ep_iso_mode, .endpoint_tx_done_flag, .usb_ep, .usb_in_token,
    .usb_setup_token, .usb_txn_ack, .usb_txn_timeout, .usb_sof, .usb_nak, .usb_send,
    .usb_data_toggle);
`default_nettype wire

//--- tb/usbt_tx_status_tb.sv
// Self-checking bench for the transmit status block
`timescale 1ns/1ps
`default_nettype none
`include "usbt_consts.vh"
module usbt_tx_status_tb;
    // ********
    // Stimulus, wiring and helpers
    // ********
    localparam logic [7:0] ST = `USBT_ADDR_STAT;
    localparam logic [7:0] FL = `USBT_ADDR_FLAG;
    localparam logic [7:0] DT = `USBT_ADDR_DATA;
    localparam logic [7:0] CT = `USBT_ADDR_COUNT;
    logic       mclk = 1'b0;
    logic       reset = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic       sfr_wr = 1'b0;
    logic       sfr_rd = 1'b0;
    logic [1:0] ep_sel = 2'h0;
    logic       fifo_clear = 1'b0;
    logic [3:0] ep_iso_mode = 4'h4;
    logic [3:0] ep_tx_enable = 4'hd;
    logic [3:0] tx_done_clear = 4'h0;
    logic [7:0] ans;
    int         n_fail = 0;
    int         n_compared = 0;
    wire  [7:0] sfr_rdata;
    wire  [3:0] endpoint_tx_done_flag;
    wire  [1:0] usb_ep;
    wire        usb_in_token, usb_setup_token, usb_rd_byte, usb_txn_ack, usb_txn_timeout;
    wire        usb_sof, usb_nak, usb_send, usb_data_toggle, usb_corrupt;
    // Clock at 50 MHz
    always #10 mclk = ~mclk;
    usbt_tx_status usbt_tx_status_i (.mclk, .reset, .clk_en(1'b1), .sfr_addr, .sfr_wdata, .sfr_wr,
        .sfr_rd, .sfr_rdata, .ep_sel, .fifo_clear, .ep_iso_mode, .ep_tx_enable, .tx_done_clear,
        .endpoint_tx_done_flag, .usb_ep, .usb_in_token, .usb_setup_token, .usb_rd_byte,
        .usb_txn_ack, .usb_txn_timeout, .usb_sof, .usb_nak, .usb_send, .usb_data_toggle,
        .usb_corrupt);
    usbt_host_model usbt_host_model_i (.mclk, .usb_nak, .usb_send, .usb_data_toggle, .usb_ep,
        .usb_in_token, .usb_rd_byte, .usb_txn_ack, .usb_txn_timeout, .usb_setup_token, .usb_sof);
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Register write and masked register read
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge mclk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge mclk);
        sfr_rd <= 1'b0;
        #1 check(sfr_rdata & m, e);
    endtask
    // Load n bytes then write the count; and a FIFO clear pulse
    task automatic load(input int n);
        repeat (n) wr(DT, 8'h5a);
        wr(CT, 8'(n));
    endtask
    task automatic clr;
        @(posedge mclk) fifo_clear <= 1'b1;
        @(posedge mclk) fifo_clear <= 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #400000;
        n_fail++;
        tally_and_finish;
    end
    // Main sequence
    initial
    begin
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        rd(ST, 8'h9f, `USBT_RST_STAT);
        rd(FL, 8'hcf, `USBT_RST_FLAG);
        rd(8'hf0, 8'hff, 8'h00);
        wr(DT, 8'h11);
        rd(FL, 8'hcf, 8'h00);
        wr(CT, 8'h01);
        rd(FL, 8'hcf, 8'h40);
        wr(CT, 8'h00);
        rd(FL, 8'hcf, 8'hc0);
        wr(CT, 8'h00);
        rd(FL, 8'hcf, 8'hc1);
        usbt_host_model_i.xfer(2'h0, 1, 1'b1, 0, ans);
        check(ans, 8'h02);
        wr(FL, 8'h00);
        clr;
        rd(FL, 8'hcf, 8'h08);
        load(2);
        usbt_host_model_i.xfer(2'h0, 2, 1'b1, 0, ans);
        check(ans, 8'h04);
        rd(ST, 8'h87, 8'h81);
        rd(FL, 8'hcf, 8'h08);
        check({4'h0, endpoint_tx_done_flag}, 8'h01);
        @(posedge mclk) tx_done_clear <= 4'h1;
        @(posedge mclk) tx_done_clear <= 4'h0;
        load(1);
        usbt_host_model_i.xfer(2'h0, 1, 1'b0, 3, ans);
        rd(ST, 8'h87, 8'h82);
        rd(FL, 8'hcf, 8'h40);
        usbt_host_model_i.xfer(2'h0, 1, 1'b1, 3, ans);
        rd(ST, 8'h87, 8'h01);
        wr(DT, 8'h22);
        wr(CT, 8'h02);
        usbt_host_model_i.xfer(2'h0, 2, 1'b0, 0, ans);
        rd(FL, 8'h03, 8'h02);
        rd(ST, 8'h03, 8'h02);
        check({7'h0, usb_corrupt}, 8'h01);
        usbt_host_model_i.xfer(2'h0, 1, 1'b1, 0, ans);
        check(ans, 8'h02);
        rd(ST, 8'h07, 8'h06);
        wr(FL, 8'h00);
        clr;
        wr(ST, 8'h80);
        rd(ST, 8'h88, 8'h00);
        wr(ST, 8'h88);
        rd(ST, 8'h88, 8'h80);
        clr;
        rd(ST, 8'h80, 8'h80);
        usbt_host_model_i.pulse(3);
        rd(ST, 8'h80, 8'h00);
        @(posedge mclk) ep_sel <= 2'h1;
        load(1);
        usbt_host_model_i.xfer(2'h1, 1, 1'b1, 0, ans);
        check(ans, 8'h02);
        rd(ST, 8'h07, 8'h04);
        check({4'h0, endpoint_tx_done_flag} & 8'h02, 8'h00);
        @(posedge mclk) ep_sel <= 2'h3;
        repeat (16) wr(DT, 8'h33);
        rd(FL, 8'hcf, 8'h04);
        wr(DT, 8'h44);
        rd(FL, 8'hcf, 8'h05);
        @(posedge mclk) ep_sel <= 2'h2;
        load(1);
        load(1);
        wr(CT, 8'h00);
        rd(FL, 8'hc1, 8'hc1);
        wr(FL, 8'h00);
        usbt_host_model_i.pulse(4);
        rd(ST, 8'h10, 8'h10);
        rd(FL, 8'hc0, 8'h40);
        usbt_host_model_i.xfer(2'h2, 1, 1'b0, 0, ans);
        rd(ST, 8'h07, 8'h00);
        usbt_host_model_i.pulse(4);
        rd(ST, 8'h07, 8'h01);
        load(0);
        usbt_host_model_i.xfer(2'h2, 1, 1'b1, 0, ans);
        rd(FL, 8'h03, 8'h00);
        usbt_host_model_i.pulse(4);
        rd(FL, 8'h03, 8'h02);
        tally_and_finish;
    end
endmodule // usbt_tx_status_tb
`default_nettype wire
